// [hdtx_defines.svh]
`ifndef HDTX_DEFINES_SVH
`define HDTX_DEFINES_SVH
// Register offsets within a port window
`define HDTX_OFS_CTRL 8'hA0
`define HDTX_OFS_DATA 8'hA2
`define HDTX_OFS_STAT 8'hA4
`define HDTX_OFS_LATCH 8'hA6
`define HDTX_OFS_IE 8'hA8
// Control field positions
`define HDTX_THR_LSB 8
`define HDTX_THR_MSB 12
`define HDTX_PSD_BIT 6
`define HDTX_FEI_BIT 5
`define HDTX_FILL_BIT 4
`define HDTX_REORD_BIT 3
`define HDTX_INV_BIT 2
`define HDTX_FCSD_BIT 1
`define HDTX_FRST_BIT 0
`define HDTX_CTRL_RESET 16'h0800
`define HDTX_CTRL_MASK 16'h1F7F
// Latched event and enable bit positions
`define HDTX_EV_OVER 5
`define HDTX_EV_UNDER 4
`define HDTX_EV_PEND 3
`define HDTX_EV_FULL 2
`define HDTX_EV_EMPTY 1
`define HDTX_EV_AVAIL 0
`define HDTX_LATCH_MASK 16'h003B
`define HDTX_IE_MASK 16'h003F
// Line patterns and CRC
`define HDTX_FLAG 8'h7E
`define HDTX_ONES 8'hFF
`define HDTX_CRC_INIT 16'hFFFF
`define HDTX_CRC_POLY 16'h8408
`define HDTX_STUFF_RUN 3'h5
// FIFO memory wake-up time after FIFO reset (frst) release; none after arst_n release
`define HDTX_WAKE_NS 200
`define HDTX_CLK_NS 25
`define HDTX_WAKE_CYC ((`HDTX_WAKE_NS + `HDTX_CLK_NS - 1) / `HDTX_CLK_NS)
`endif

// [hdtx_pkg.sv]
package hdtx_pkg;
   typedef struct packed {
      logic [7:0] data;
      logic       pend;
   } hdtx_entry_s;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DATA  = 3'b001,
      ST_FCS_L = 3'b010,
      ST_FCS_H = 3'b011,
      ST_CLOSE = 3'b100
   } hdtx_state_e;
endpackage

// [hdtx_top.sv]
`timescale 1ns/10ps
`include "hdtx_defines.svh"
module hdtx_top #(
   parameter int DEPTH = 256,
   parameter logic [1:0] PORT = 2'h0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic bus_sel,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [11:0] bus_addr,
   input wire logic [1:0] bus_be,
   input wire logic [15:0] bus_wdata,
   output logic [15:0] bus_rdata,
   input wire logic [3:0] port_irq_enable_field,
   input wire logic bit_req,
   output logic tx_bit,
   output logic tx_bit_valid,
   output logic irq
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [4:0] WAKE_C = 5'(`HDTX_WAKE_CYC);

   ////////////////////////////////////////////////////////////////////////
   // Register decode
   logic [15:0] ctrl;
   logic [15:0] latch;
   logic [15:0] ie;
   wire port_hit = bus_sel && (bus_addr[11:9] == {PORT, 1'b0} >> 1) && !bus_addr[8];
   wire [7:0] ofs = bus_addr[7:0];
   wire wr_ctrl = port_hit && bus_wr && ofs == `HDTX_OFS_CTRL;
   wire wr_data = port_hit && bus_wr && ofs == `HDTX_OFS_DATA && bus_be[1];
   wire wr_latch = port_hit && bus_wr && ofs == `HDTX_OFS_LATCH;
   wire wr_ie = port_hit && bus_wr && ofs == `HDTX_OFS_IE;
   wire [15:0] be_mask = {{8{bus_be[1]}}, {8{bus_be[0]}}};
   wire frst = ctrl[`HDTX_FRST_BIT];
   wire fcs_disable = ctrl[`HDTX_FCSD_BIT];
   wire fcs_error_insert = ctrl[`HDTX_FEI_BIT];
   wire packet_start_disable = ctrl[`HDTX_PSD_BIT];
   wire [4:0] free_space_threshold = ctrl[`HDTX_THR_MSB:`HDTX_THR_LSB];

   ////////////////////////////////////////////////////////////////////////
   // Transmit FIFO
   hdtx_pkg::hdtx_entry_s mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] count;
   logic [4:0] wake;
   logic frst_q;
   wire fifo_full = count == DEPTH_C;
   wire fifo_empty = count == '0;
   wire [AW:0] free_bytes = DEPTH_C - count;
   wire [AW:0] need = (AW+1)'({free_space_threshold, 3'b000}) + (AW+1)'(1);
   wire storage_available = free_bytes >= need;
   wire [5:0] free_group_count = 6'(free_bytes >> 3);
   wire accepting = !frst && wake == '0;
   wire push = wr_data && accepting && !fifo_full;
   wire overflow_ev = wr_data && accepting && fifo_full;
   wire frst_fall = frst_q && !frst;
   // Two-entry buffer between FIFO memory and serializer
   hdtx_pkg::hdtx_entry_s buf_q [2];
   logic [1:0] buf_cnt;
   logic buf_rd;
   wire buf_ready = buf_cnt != 2'h2;
   wire buf_valid = buf_cnt != 2'h0;
   wire fifo_pop = !fifo_empty && buf_ready && !frst;
   logic pop_buf;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr] <= '{data: bus_wdata[15:8], pend: bus_wdata[0] && bus_be[0]};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         frst_q <= 1'b0;
         wake <= 5'h00;
      end else begin
         frst_q <= frst;
         wptr <= frst ? '0 : wptr + AW'(push);
         rptr <= frst ? '0 : rptr + AW'(fifo_pop);
         count <= frst ? '0 : count + (AW+1)'(push) - (AW+1)'(fifo_pop);
         wake <= frst ? WAKE_C : (wake != '0 ? wake - 5'h01 : wake);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_cnt <= 2'h0;
         buf_rd <= 1'b0;
         buf_q[0] <= '0;
         buf_q[1] <= '0;
      end else if (frst) begin
         buf_cnt <= 2'h0;
         buf_rd <= 1'b0;
      end else begin
         if (fifo_pop) begin
            // Tail slot is read slot plus fill, whether or not head leaves now
            buf_q[buf_rd ^ (buf_cnt == 2'h1)] <= mem[rptr];
         end
         buf_rd <= buf_rd ^ pop_buf;
         buf_cnt <= buf_cnt + 2'(fifo_pop) - 2'(pop_buf);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Packet sequencer and serializer
   hdtx_pkg::hdtx_state_e state;
   hdtx_pkg::hdtx_state_e next_state;
   logic [7:0] sh;
   logic [3:0] cnt;
   logic [2:0] ones;
   logic raw;
   logic crc_on;
   logic [15:0] crc;
   logic underflow_ev;
   logic pend_ev;
   logic [7:0] next_sh;
   logic next_raw;
   logic next_crc_on;
   hdtx_pkg::hdtx_entry_s head;
   assign head = buf_q[buf_rd];
   wire stuff_due = !raw && ones == `HDTX_STUFF_RUN;
   wire load = cnt == 4'h0 && !stuff_due && !frst;
   wire [15:0] fcs_val = fcs_error_insert ? crc : ~crc;
   wire [7:0] data_ord = ctrl[`HDTX_REORD_BIT] ? {<<{head.data}} : head.data;
   wire [7:0] fill = ctrl[`HDTX_FILL_BIT] ? `HDTX_ONES : `HDTX_FLAG;
   wire shift_out = bit_req && !stuff_due && cnt != 4'h0;
   wire line_bit = stuff_due ? 1'b0 : sh[0];
   wire crc_fb = crc[0] ^ sh[0];

   always_comb begin
      next_state = state;
      next_sh = fill;
      next_raw = 1'b1;
      next_crc_on = 1'b0;
      pop_buf = 1'b0;
      underflow_ev = 1'b0;
      pend_ev = 1'b0;
      case (state)
         hdtx_pkg::ST_IDLE: begin
            if (buf_valid && !packet_start_disable) begin
               next_sh = `HDTX_FLAG;
               next_state = hdtx_pkg::ST_DATA;
            end
         end
         hdtx_pkg::ST_DATA: begin
            if (buf_valid) begin
               pop_buf = load;
               pend_ev = load && head.pend;
               next_sh = data_ord;
               next_raw = 1'b0;
               next_crc_on = 1'b1;
               if (head.pend) begin
                  next_state = fcs_disable ? hdtx_pkg::ST_CLOSE : hdtx_pkg::ST_FCS_L;
               end
            end else begin
               // Abort pattern on a dry FIFO
               underflow_ev = load;
               next_sh = `HDTX_ONES;
               next_state = hdtx_pkg::ST_IDLE;
            end
         end
         hdtx_pkg::ST_FCS_L: begin
            next_sh = fcs_val[7:0];
            next_raw = 1'b0;
            next_state = hdtx_pkg::ST_FCS_H;
         end
         hdtx_pkg::ST_FCS_H: begin
            next_sh = fcs_val[15:8];
            next_raw = 1'b0;
            next_state = hdtx_pkg::ST_CLOSE;
         end
         hdtx_pkg::ST_CLOSE: begin
            next_sh = `HDTX_FLAG;
            next_state = hdtx_pkg::ST_IDLE;
         end
         default: begin
            next_state = hdtx_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= hdtx_pkg::ST_IDLE;
         sh <= 8'hFF;
         cnt <= 4'h0;
         raw <= 1'b1;
         crc_on <= 1'b0;
         ones <= 3'h0;
         crc <= `HDTX_CRC_INIT;
      end else if (frst) begin
         state <= hdtx_pkg::ST_IDLE;
         cnt <= 4'h0;
         raw <= 1'b1;
         ones <= 3'h0;
      end else if (load) begin
         state <= next_state;
         sh <= next_sh;
         cnt <= 4'h8;
         raw <= next_raw;
         crc_on <= next_crc_on;
         if (state == hdtx_pkg::ST_IDLE) begin
            crc <= `HDTX_CRC_INIT;
         end
      end else if (bit_req && stuff_due) begin
         ones <= 3'h0;
      end else if (shift_out) begin
         sh <= {1'b1, sh[7:1]};
         cnt <= cnt - 4'h1;
         ones <= (raw || !sh[0]) ? 3'h0 : ones + 3'h1;
         if (crc_on) begin
            crc <= (crc >> 1) ^ (crc_fb ? `HDTX_CRC_POLY : 16'h0000);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_bit <= 1'b1;
         tx_bit_valid <= 1'b0;
      end else begin
         tx_bit_valid <= bit_req && (stuff_due || cnt != 4'h0) && !frst;
         if (bit_req && (stuff_due || cnt != 4'h0)) begin
            tx_bit <= line_bit ^ ctrl[`HDTX_INV_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Events, registers and read-back
   logic empty_q;
   logic avail_q;
   wire [15:0] ev_set = {10'h000, overflow_ev, underflow_ev, pend_ev, 1'b0,
                         (fifo_empty && !empty_q) || frst_fall,
                         (storage_available && !avail_q) || frst_fall};
   wire [15:0] status = {2'b00, free_group_count, 5'h00, fifo_full, fifo_empty,
                         storage_available};
   wire [15:0] rd_mux = !port_hit ? 16'h0000 :
                        ofs == `HDTX_OFS_CTRL ? ctrl :
                        ofs == `HDTX_OFS_STAT ? status :
                        ofs == `HDTX_OFS_LATCH ? latch :
                        ofs == `HDTX_OFS_IE ? ie : 16'h0000;
   wire irq_any = |(latch & ie & `HDTX_LATCH_MASK) && port_irq_enable_field[PORT];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= `HDTX_CTRL_RESET;
         ie <= 16'h0000;
         latch <= 16'h0000;
         empty_q <= 1'b1;
         avail_q <= 1'b1;
         bus_rdata <= 16'h0000;
         irq <= 1'b0;
      end else begin
         empty_q <= fifo_empty;
         avail_q <= storage_available;
         irq <= irq_any;
         if (wr_ctrl) begin
            ctrl <= (ctrl & ~be_mask) | (bus_wdata & be_mask & `HDTX_CTRL_MASK);
         end
         if (wr_ie) begin
            ie <= (ie & ~be_mask) | (bus_wdata & be_mask & `HDTX_IE_MASK);
         end
         // A new event in the clearing cycle survives the clear
         latch <= ((latch & ~(wr_latch ? bus_wdata & be_mask : 16'h0000)) | ev_set)
                  & `HDTX_LATCH_MASK;
         bus_rdata <= (port_hit && bus_rd) ? rd_mux : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_AVAIL_LEVEL: assert property (@(posedge clk) disable iff (!arst_n)
      storage_available == (free_bytes >= need))
      else $error("storage available mismatch");
   AST_PSD_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      state == hdtx_pkg::ST_IDLE && packet_start_disable && load |=> state == hdtx_pkg::ST_IDLE)
      else $error("packet started while disabled");
   AST_FCS_SKIP: assert property (@(posedge clk) disable iff (!arst_n)
      state == hdtx_pkg::ST_DATA && load && buf_valid && head.pend && fcs_disable
      |=> state == hdtx_pkg::ST_CLOSE)
      else $error("FCS sent while disabled");
   AST_INVERT: assert property (@(posedge clk) disable iff (!arst_n)
      bit_req && cnt != 4'h0 && !stuff_due && !frst
      |=> tx_bit_valid && tx_bit == ($past(sh[0]) ^ $past(ctrl[`HDTX_INV_BIT])))
      else $error("output bit wrong");
   AST_RESET_DROP: assert property (@(posedge clk) disable iff (!arst_n)
      frst && wr_data |=> count == '0)
      else $error("write taken during FIFO reset");
   AST_WAKE_DISCARD: assert property (@(posedge clk) disable iff (!arst_n)
      frst_fall |-> !push [*8])
      else $error("write taken during wake-up");
   AST_PUSH_COUNT: assert property (@(posedge clk) disable iff (!arst_n)
      push && !fifo_pop |=> count == $past(count) + (AW+1)'(1))
      else $error("push lost");
   AST_FULL: assert property (@(posedge clk) disable iff (!arst_n)
      fifo_full |-> count == DEPTH_C && free_group_count == 6'h00)
      else $error("full flag wrong");
   AST_OVERFLOW: assert property (@(posedge clk) disable iff (!arst_n)
      overflow_ev |=> latch[`HDTX_EV_OVER])
      else $error("overflow not latched");
   AST_EMPTY_EV: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(fifo_empty) |=> latch[`HDTX_EV_EMPTY])
      else $error("empty event missed");
   AST_IRQ: assert property (@(posedge clk) disable iff (!arst_n)
      irq |-> $past(port_irq_enable_field[PORT]) && $past(|(latch & ie)))
      else $error("interrupt without cause");
endmodule

// [hdtx_bit_sink.sv]
`timescale 1ns/10ps
module hdtx_bit_sink (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic en,
   output logic bit_req,
   input wire logic tx_bit,
   input wire logic tx_bit_valid
);
   logic bits[$];
   int gap;
   initial begin
      bit_req = 1'b0;
      gap = 0;
   end
   // Requests spaced three cycles apart, so a reload cycle is never hit
   always @(posedge clk) begin
      #1;
      bit_req = 1'b0;
      gap = (gap == 2) ? 0 : gap + 1;
      if (arst_n && en && gap == 0) begin
         bit_req = 1'b1;
      end
   end
   always @(posedge clk) begin
      if (tx_bit_valid === 1'b1) begin
         bits.push_back(tx_bit);
      end
   end
endmodule

// [tb.sv]
`timescale 1ns/10ps
`include "hdtx_defines.svh"
module tb;
   logic clk, arst_n, bus_sel, bus_wr, bus_rd, bit_req, tx_bit, tx_bit_valid, irq, sink_en;
   logic [11:0] bus_addr;
   logic [1:0] bus_be;
   logic [15:0] bus_wdata, bus_rdata, v;
   logic [3:0] port_irq_enable_field;
   logic [23:0] got;
   int n_errors, checked, n, k;
   hdtx_top u_dut (.clk(clk), .arst_n(arst_n), .bus_sel(bus_sel), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .port_irq_enable_field(port_irq_enable_field),
      .bit_req(bit_req), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .irq(irq));
   hdtx_bit_sink u_sink (.clk(clk), .arst_n(arst_n), .en(sink_en), .bit_req(bit_req),
      .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic wr(input logic [7:0] ofs, input logic [15:0] d);
      @(posedge clk) #1;
      {bus_sel, bus_wr, bus_addr, bus_be, bus_wdata} = {2'b11, 4'h0, ofs, 2'b11, d};
      @(posedge clk) #1;
      {bus_sel, bus_wr} = 2'b00;
   endtask
   task automatic rd(input logic [7:0] ofs, output logic [15:0] d);
      @(posedge clk) #1;
      {bus_sel, bus_rd, bus_addr} = {2'b11, 4'h0, ofs};
      @(posedge clk) #1;
      d = bus_rdata;
      {bus_sel, bus_rd} = 2'b00;
   endtask
   task automatic chk(input logic [23:0] g, input logic [23:0] e, input string m);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #(25 * 60000);
      n_errors++;
      report_and_stop;
   end
   initial begin
      logic [7:0] cfg[3] = '{8'h12, 8'h1A, 8'h16};
      {arst_n, bus_sel, bus_wr, bus_rd, sink_en} = 5'b00000;
      {bus_addr, bus_be, bus_wdata, port_irq_enable_field} = '0;
      n_errors = 0;
      checked = 0;
      repeat (5) @(posedge clk);
      #1 arst_n = 1'b1;
      rd(`HDTX_OFS_CTRL, v); chk(v, 24'h0800, "ctrl reset");
      rd(`HDTX_OFS_STAT, v); chk(v, 24'h2003, "status idle");
      rd(`HDTX_OFS_DATA, v); chk(v, 24'h0, "data port read");
      rd(8'hAA, v); chk(v, 24'h0, "unmapped read");
      $display("test reset done");
      // Line side stalled: FIFO plus the two-entry buffer take all writes
      for (n = 1; n < 262; n++) begin
         wr(`HDTX_OFS_DATA, {n[7:0], 8'h01});
         rd(`HDTX_OFS_STAT, v);
         if (v[2] === 1'b1) break;
         // First two bytes move on into the two-entry buffer
         if (n == 3) chk(v, 24'h1F01, "one byte");
      end
      chk(n >= 256 && n <= 259, 24'h1, "full count");
      chk(v, 24'h0004, "full status");
      wr(`HDTX_OFS_DATA, 16'hAB01);
      rd(`HDTX_OFS_LATCH, v); chk(v[5], 24'h1, "overflow");
      wr(`HDTX_OFS_CTRL, 16'h0801);
      rd(`HDTX_OFS_STAT, v); chk(v, 24'h2003, "fifo reset");
      wr(`HDTX_OFS_CTRL, 16'h0800);
      wr(`HDTX_OFS_DATA, 16'h5501);
      rd(`HDTX_OFS_STAT, v); chk(v, 24'h2003, "wake discard");
      rd(`HDTX_OFS_LATCH, v); chk(v & 16'h0023, 24'h0023, "release events");
      $display("test fill done");
      wr(`HDTX_OFS_IE, 16'h0020);
      repeat (3) @(posedge clk);
      chk(irq, 24'h0, "port disabled");
      #1 port_irq_enable_field = 4'h1;
      repeat (3) @(posedge clk);
      chk(irq, 24'h1, "irq on");
      wr(`HDTX_OFS_LATCH, 16'h003F);
      repeat (3) @(posedge clk);
      chk(irq, 24'h0, "irq cleared");
      rd(`HDTX_OFS_LATCH, v); chk(v, 24'h0, "latch cleared");
      $display("test irq done");
      for (int c = 0; c < 3; c++) begin
         wr(`HDTX_OFS_CTRL, {8'h08, cfg[c]});
         // Drain fill loaded under the old setting before the frame
         #1 sink_en = 1'b1;
         repeat (45) @(posedge clk);
         u_sink.bits.delete();
         wr(`HDTX_OFS_DATA, 16'h1C01);
         repeat (400) @(posedge clk);
         #1 sink_en = 1'b0;
         repeat (10) @(posedge clk);
         k = 0;
         // First bit off the fill level opens the flag
         while (k < 100 && u_sink.bits[k] === !cfg[c][2]) k++;
         got = '0;
         for (int i = 0; i < 24; i++) got = {got[22:0], u_sink.bits[k + i]};
         chk(got, {8'h7E, cfg[c][3] ? 8'h1C : 8'h38, 8'h7E} ^ {24{cfg[c][2]}},
            "frame bits");
         rd(`HDTX_OFS_LATCH, v); chk(v[3], 24'h1, "packet end");
         wr(`HDTX_OFS_LATCH, 16'h003F);
         $display("test frame %0d done", c);
      end
      report_and_stop;
   end
endmodule
